// ---- hw/tsel_pkg.sv ----
package tsel_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] TSEL_ADDR_STATUS = 4'h0; // Tape status register
  localparam logic [3:0] TSEL_ADDR_CMD_LO = 4'h1; // Command register low byte
  localparam logic [3:0] TSEL_ADDR_CMD_HI = 4'h2; // Command register high byte
  localparam logic [3:0] TSEL_ADDR_CTRL = 4'h3;   // Controller state word

  // ****************************************************************
  // Status register field positions
  // ****************************************************************
  localparam int TSEL_BIT_ILLEGAL = 15;
  localparam int TSEL_BIT_EOF = 14;
  localparam int TSEL_BIT_CRC = 13;
  localparam int TSEL_BIT_PARITY = 12;
  localparam int TSEL_BIT_GRANT_LATE = 11;
  localparam int TSEL_BIT_TAPE_END = 10;
  localparam int TSEL_XPORT_W = 6;          // Bits 05..00 come from the transport
  localparam int TSEL_BIT_SEL_ONLINE = 6;   // Selected and on-line status bit

  // Control word bit positions (controller state word)
  localparam int TSEL_CTL_ERR = 0;
  localparam int TSEL_CTL_RDY = 1;
  localparam int TSEL_CTL_DONE = 2;
  localparam int TSEL_CTL_BREQ = 3;
  localparam int TSEL_CTL_DMA = 4;
  localparam int TSEL_CTL_W = 5;

  localparam logic [15:0] TSEL_ZERO16 = 16'h0000;

  // GO sequence states, Gray coded along the usual path
  typedef enum logic [1:0] {
    TSEL_GO_IDLE = 2'b00,
    TSEL_GO_S1 = 2'b01,
    TSEL_GO_S2 = 2'b11,
    TSEL_GO_RUN = 2'b10
  } tsel_go_e;

endpackage : tsel_pkg

// ---- hw/tsel_edge.sv ----
`timescale 1ns/1ps
// Rising and falling edge detector on a synchronous level
module tsel_edge (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);

  logic prev_q;

  // Remember last level
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;

endmodule : tsel_edge

// ---- hw/tsel_status.sv ----
`timescale 1ns/1ps
module tsel_status
  import tsel_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Controller context
  input wire logic initialize_i,
  input wire logic write_function_active_i,
  input wire logic read_function_i,
  input wire logic offline_function_i,
  input wire logic reverse_motion_i,
  // Transport
  input wire logic [tsel_pkg::TSEL_XPORT_W-1:0] transport_status_i,
  input wire logic selected_online_i,
  input wire logic write_lock_i,
  input wire logic tape_unit_ready_i,
  input wire logic file_mark_detected_i,
  input wire logic crc_mismatch_i,
  input wire logic vertical_parity_fault_i,
  input wire logic longitudinal_parity_fault_i,
  input wire logic check_char_detected_i,
  input wire logic read_strobe_i,
  input wire logic write_strobe_i,
  input wire logic end_of_tape_i,
  input wire logic dma_done_i,
  // Results
  output logic go_pulse_o,
  output logic error_o,
  output logic controller_ready_o,
  output logic set_bus_request_o,
  output logic dma_request_o
);
  import tsel_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (ADDR_W < 2) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  tsel_go_e go_q;
  tsel_go_e go_d;
  logic illegal_command_flag_q;
  logic eof_flag_q;
  logic crc_error_flag_q;
  logic parity_error_flag_q;
  logic bus_grant_late_flag_q;
  logic end_of_tape_flag_q;
  logic error_q;
  logic done_q;
  logic controller_ready_q;
  logic set_bus_request_q;
  logic dma_request_q;
  logic dma_pulse_q;
  logic go_pulse_q;
  logic op_q;
  logic [15:0] rdata_q;
  logic go_bit_q;

  logic go_strobe1;
  logic go_strobe2;
  logic clear_err;
  logic cmd_write;
  logic online_fall;
  logic tape_end_fall;
  logic illegal_set;
  logic dma_request_pulse;
  logic dma_trailing;
  logic deferred_err;
  logic any_error;
  logic [15:0] status_word;
  logic [TSEL_CTL_W-1:0] ctl_word;
  logic unused_wdata;

  // Only data bit 00, the GO bit of the low command byte, is stored; other data bits never are
  assign unused_wdata = |reg_wdata_i;

  // Edge detectors on the transport lines
  tsel_edge u_online_edge (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .level_i(selected_online_i),
    .rise_o(),
    .fall_o(online_fall)
  );

  tsel_edge u_tape_end_edge (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .level_i(end_of_tape_i),
    .rise_o(),
    .fall_o(tape_end_fall)
  );

  // ****************************************************************
  // Command writes and GO sequencing
  // ****************************************************************
  assign cmd_write = reg_wr_i & ((reg_addr_i == ADDR_W'(TSEL_ADDR_CMD_LO)) |
                                 (reg_addr_i == ADDR_W'(TSEL_ADDR_CMD_HI)));

  // GO bit is bit 00 of the low command byte
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || initialize_i) begin
      go_bit_q <= 1'b0;
    end else if (go_strobe2) begin
      go_bit_q <= 1'b0;
    end else if (cmd_write && !op_q && reg_addr_i == ADDR_W'(TSEL_ADDR_CMD_LO) && reg_wdata_i[0]) begin
      go_bit_q <= 1'b1;
    end
  end

  // Strobe 1 always precedes strobe 2 by one cycle
  always_comb begin
    go_d = go_q;
    case (go_q)
      TSEL_GO_IDLE: begin
        if (go_bit_q) begin
          go_d = TSEL_GO_S1;
        end
      end
      TSEL_GO_S1: begin
        go_d = TSEL_GO_S2;
      end
      TSEL_GO_S2: begin
        go_d = TSEL_GO_RUN;
      end
      TSEL_GO_RUN: begin
        if (!go_bit_q) begin
          go_d = TSEL_GO_IDLE;
        end
      end
      default: begin
        go_d = TSEL_GO_IDLE;
      end
    endcase
  end

  assign go_strobe1 = (go_q == TSEL_GO_S1);
  assign go_strobe2 = (go_q == TSEL_GO_S2);
  assign clear_err = initialize_i | go_strobe1;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || initialize_i) begin
      go_q <= TSEL_GO_IDLE;
    end else begin
      go_q <= go_d;
    end
  end

  // Operation in progress from second strobe until done
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || initialize_i) begin
      op_q <= 1'b0;
    end else if (go_strobe2 && !illegal_set) begin
      op_q <= 1'b1;
    end else if (check_char_detected_i || any_error) begin
      op_q <= 1'b0;
    end
  end

  // GO pulse to the transport, only for a legal command
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      go_pulse_q <= 1'b0;
    end else begin
      go_pulse_q <= go_strobe2 & ~illegal_set;
    end
  end

  // ****************************************************************
  // Error flags
  // ****************************************************************
  assign illegal_set = (cmd_write & op_q) |
                   (online_fall & op_q & ~offline_function_i) |
                   (go_strobe2 & ~selected_online_i) |
                   (go_strobe2 & write_function_active_i & write_lock_i);

  // Illegal command: the set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      illegal_command_flag_q <= 1'b0;
    end else if (illegal_set) begin
      illegal_command_flag_q <= 1'b1;
    end else if (clear_err) begin
      illegal_command_flag_q <= 1'b0;
    end
  end

  // End of file
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      eof_flag_q <= 1'b0;
    end else if (file_mark_detected_i) begin
      eof_flag_q <= 1'b1;
    end else if (clear_err) begin
      eof_flag_q <= 1'b0;
    end
  end

  // CRC error, immediate in status
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      crc_error_flag_q <= 1'b0;
    end else if (crc_mismatch_i) begin
      crc_error_flag_q <= 1'b1;
    end else if (clear_err) begin
      crc_error_flag_q <= 1'b0;
    end
  end

  // Parity sampled on every read strobe during a read or write function, check characters included
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      parity_error_flag_q <= 1'b0;
    end else if (read_strobe_i && (write_function_active_i || read_function_i) &&
                 (vertical_parity_fault_i || longitudinal_parity_fault_i)) begin
      parity_error_flag_q <= 1'b1;
    end else if (clear_err) begin
      parity_error_flag_q <= 1'b0;
    end
  end

  // ****************************************************************
  // DMA request path
  // ****************************************************************
  assign dma_request_pulse = read_strobe_i | write_strobe_i;

  // Delay the pulse so the request rises on its trailing edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dma_pulse_q <= 1'b0;
    end else begin
      dma_pulse_q <= dma_request_pulse;
    end
  end

  assign dma_trailing = dma_pulse_q & ~dma_request_pulse;

  // Bus grant late: new pulse while a request is still pending
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bus_grant_late_flag_q <= 1'b0;
    end else if (dma_request_pulse && !dma_pulse_q && dma_request_q) begin
      bus_grant_late_flag_q <= 1'b1;
    end else if (clear_err) begin
      bus_grant_late_flag_q <= 1'b0;
    end
  end

  // Request set on trailing edge unless blocked; a late grant blocks all
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || initialize_i) begin
      dma_request_q <= 1'b0;
    end else if (dma_trailing && !bus_grant_late_flag_q) begin
      dma_request_q <= 1'b1;
    end else if (dma_done_i) begin
      dma_request_q <= 1'b0;
    end
  end

  // End of tape follows the marker by direction
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      end_of_tape_flag_q <= 1'b0;
    end else if (end_of_tape_i && !reverse_motion_i) begin
      end_of_tape_flag_q <= 1'b1;
    end else if ((tape_end_fall && reverse_motion_i) || clear_err) begin
      end_of_tape_flag_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Error summary and ready path
  // ****************************************************************
  // Soft errors wait for the check character so the record finishes
  assign deferred_err = check_char_detected_i &
                        (crc_error_flag_q | parity_error_flag_q |
                         (end_of_tape_flag_q & ~reverse_motion_i));
  assign any_error = illegal_set | illegal_command_flag_q | eof_flag_q |
                     bus_grant_late_flag_q | deferred_err;

  // Error flag of the command register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      error_q <= 1'b0;
    end else if (illegal_set) begin
      error_q <= 1'b1;
    end else if (go_strobe1 || initialize_i) begin
      error_q <= 1'b0;
    end else if (any_error) begin
      error_q <= 1'b1;
    end
  end

  // Transfer done; a new GO drops a stale done so old flags cannot keep ready up
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || initialize_i) begin
      done_q <= 1'b0;
    end else if (illegal_set || (op_q && check_char_detected_i)) begin
      done_q <= 1'b1;
    end else if (go_bit_q) begin
      done_q <= 1'b0;
    end else if (any_error) begin
      done_q <= 1'b1;
    end
  end

  // Ready: illegal command at once, else GO clears it and done with unit ready sets it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || initialize_i) begin
      controller_ready_q <= 1'b1;
    end else if (illegal_set) begin
      controller_ready_q <= 1'b1;
    end else if (go_bit_q) begin
      controller_ready_q <= 1'b0;
    end else if (done_q && tape_unit_ready_i) begin
      controller_ready_q <= 1'b1;
    end
  end

  // Bus request pulse toward the interrupt logic
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      set_bus_request_q <= 1'b0;
    end else begin
      set_bus_request_q <= illegal_set | (done_q & tape_unit_ready_i & ~controller_ready_q);
    end
  end

  // ****************************************************************
  // Read port; writes to the status word have no effect
  // ****************************************************************
  assign status_word = {illegal_command_flag_q, eof_flag_q, crc_error_flag_q, parity_error_flag_q,
                        bus_grant_late_flag_q, end_of_tape_flag_q, 3'b000, selected_online_i,
                        transport_status_i};
  assign ctl_word = {dma_request_q, set_bus_request_q, done_q, controller_ready_q, error_q};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_q <= TSEL_ZERO16;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ADDR_W'(TSEL_ADDR_STATUS)) begin
        rdata_q <= status_word;
      end else if (reg_addr_i == ADDR_W'(TSEL_ADDR_CTRL)) begin
        rdata_q <= {{(16 - TSEL_CTL_W){1'b0}}, ctl_word};
      end else begin
        rdata_q <= TSEL_ZERO16;
      end
    end else begin
      rdata_q <= TSEL_ZERO16;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign go_pulse_o = go_pulse_q;
  assign error_o = error_q;
  assign controller_ready_o = controller_ready_q;
  assign set_bus_request_o = set_bus_request_q;
  assign dma_request_o = dma_request_q;

endmodule : tsel_status

// ---- verif/tsel_status_checker.sv ----
`timescale 1ns/1ps
// ****
// Port checks
// ****
module tsel_status_checker #(
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [tsel_pkg::TSEL_XPORT_W-1:0] transport_status_i,
  input wire logic selected_online_i,
  input wire logic initialize_i,
  input wire logic tape_unit_ready_i,
  input wire logic read_strobe_i,
  input wire logic write_strobe_i,
  input wire logic dma_done_i,
  input wire logic go_pulse_o,
  input wire logic error_o,
  input wire logic controller_ready_o,
  input wire logic set_bus_request_o,
  input wire logic dma_request_o
);
  import tsel_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Read data stand one cycle only, so idle cycles show zero
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == TSEL_ZERO16;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  // Low status bits mirror the transport as sampled with the strobe
  property p_status_low;
    $past(reg_rd_i) && $past(reg_addr_i) == TSEL_ADDR_STATUS
      |-> reg_rdata_o[9:0] == {3'h0, $past(selected_online_i), $past(transport_status_i)};
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits wrong");
  property p_go_one;
    go_pulse_o |=> !go_pulse_o;
  endproperty
  a_go_one: assert property (p_go_one) else $error("go pulse too long");
  property p_sbr_one;
    set_bus_request_o |=> !set_bus_request_o;
  endproperty
  a_sbr_one: assert property (p_sbr_one) else $error("bus request pulse too long");
  // Trailing edge of a strobe raises the request unless blocked
  property p_dma_set;
    ($fell(read_strobe_i) || $fell(write_strobe_i)) && !error_o |-> ##[0:2] dma_request_o;
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("no dma request");
  property p_dma_clr;
    dma_done_i && !read_strobe_i && !write_strobe_i && !$past(read_strobe_i) && !$past(write_strobe_i)
      && !$past(read_strobe_i, 2) && !$past(write_strobe_i, 2) |=> !dma_request_o;
  endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("dma request not cleared");
  property p_init;
    initialize_i |=> controller_ready_o;
  endproperty
  a_init: assert property (p_init) else $error("not ready after initialize");
  property p_ready_err;
    $rose(error_o) && tape_unit_ready_i |-> ##[0:2] controller_ready_o;
  endproperty
  a_ready_err: assert property (p_ready_err) else $error("error did not make ready");
endmodule : tsel_status_checker

bind tsel_status tsel_status_checker #(.ADDR_W(ADDR_W)) i_tsel_status_checker (.clk_sys_i, .reset_i,
  .reg_addr_i, .reg_rd_i, .reg_rdata_o, .transport_status_i, .selected_online_i, .initialize_i,
  .tape_unit_ready_i, .read_strobe_i, .write_strobe_i, .dma_done_i, .go_pulse_o, .error_o,
  .controller_ready_o, .set_bus_request_o, .dma_request_o);

// ---- verif/tsel_xpm.sv ----
`timescale 1ns/1ps
// ****
// Transport stand-in
// ****
module tsel_xpm (
  input wire logic clk_sys_i,
  output logic [5:0] status_o,
  output logic online_o,
  output logic wlock_o,
  output logic ready_o,
  output logic fmark_o,
  output logic crc_o,
  output logic vpar_o,
  output logic lpar_o,
  output logic check_o,
  output logic read_stb_o,
  output logic write_stb_o,
  output logic tape_end_o
);
  // Idle unit: on-line and ready, no events
  initial begin
    {status_o, online_o, wlock_o, ready_o, vpar_o, lpar_o, tape_end_o} = 12'haa8;
    {fmark_o, crc_o, check_o, read_stb_o, write_stb_o} = 5'h00;
  end
  // Levels change just after an edge: online, lock, parity, marker
  task automatic levels(input logic [5:0] st, input logic [4:0] lv);
    @(posedge clk_sys_i);
    status_o <= st;
    {online_o, wlock_o, vpar_o, lpar_o, tape_end_o} <= lv;
  endtask : levels
  // One-cycle event; the gap lets the unit answer late
  task automatic pulse(input int k, input int gap);
    repeat (gap + 1) @(posedge clk_sys_i);
    {fmark_o, crc_o, check_o, read_stb_o, write_stb_o} <= 5'(5'h10 >> k);
    @(posedge clk_sys_i);
    {fmark_o, crc_o, check_o, read_stb_o, write_stb_o} <= 5'h00;
  endtask : pulse
endmodule : tsel_xpm

// ---- verif/tape_status_error_logic_test.sv ----
`timescale 1ns/1ps
// ****
// Status block bench
// ****
module tape_status_error_logic_test;
  import tsel_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic initialize_i = 1'b0;
  logic write_function_active_i = 1'b0;
  logic read_function_i = 1'b0;
  logic offline_function_i = 1'b0;
  logic reverse_motion_i = 1'b0;
  logic dma_done_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [5:0] transport_status_i;
  logic selected_online_i, write_lock_i, tape_unit_ready_i, file_mark_detected_i, crc_mismatch_i;
  logic vertical_parity_fault_i, longitudinal_parity_fault_i, check_char_detected_i;
  logic read_strobe_i, write_strobe_i, end_of_tape_i;
  logic go_pulse_o, error_o, controller_ready_o, set_bus_request_o, dma_request_o;
  logic [4:0] outs;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign outs = {dma_request_o, controller_ready_o, error_o, set_bus_request_o, go_pulse_o};
  tsel_status i_tsel_status (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .initialize_i, .write_function_active_i, .read_function_i, .offline_function_i,
    .reverse_motion_i, .transport_status_i, .selected_online_i, .write_lock_i, .tape_unit_ready_i,
    .file_mark_detected_i, .crc_mismatch_i, .vertical_parity_fault_i, .longitudinal_parity_fault_i,
    .check_char_detected_i, .read_strobe_i, .write_strobe_i, .end_of_tape_i, .dma_done_i, .go_pulse_o,
    .error_o, .controller_ready_o, .set_bus_request_o, .dma_request_o);
  tsel_xpm i_tsel_xpm (.clk_sys_i, .status_o(transport_status_i), .online_o(selected_online_i),
    .wlock_o(write_lock_i), .ready_o(tape_unit_ready_i), .fmark_o(file_mark_detected_i),
    .crc_o(crc_mismatch_i), .vpar_o(vertical_parity_fault_i), .lpar_o(longitudinal_parity_fault_i),
    .check_o(check_char_detected_i), .read_stb_o(read_strobe_i), .write_stb_o(write_strobe_i),
    .tape_end_o(end_of_tape_i));
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string w, input logic e, input logic g);
    chk(w, {15'h0000, e}, {15'h0000, g});
  endtask : chk_bit
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Status read; data stand only in the cycle after the strobe
  task automatic st(input logic [15:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= TSEL_ADDR_STATUS;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("status", e, reg_rdata_o);
  endtask : st
  // Bounded wait for one result line
  task automatic hi(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (outs[k] !== 1'b1 && n < 20);
    chk_bit("wait", 1'b1, outs[k]);
  endtask : hi
  task automatic done();
    @(posedge clk_sys_i);
    dma_done_i <= 1'b1;
    @(posedge clk_sys_i);
    dma_done_i <= 1'b0;
  endtask : done
  // Start a command, optionally from a clean initialize
  task automatic go(input logic ini);
    if (ini) begin
      @(posedge clk_sys_i);
      initialize_i <= 1'b1;
      @(posedge clk_sys_i);
      initialize_i <= 1'b0;
    end
    wr(TSEL_ADDR_CMD_LO, 16'h0001);
  endtask : go
  task automatic t_regs();
    st(16'h006a);
    i_tsel_xpm.levels(6'h15, 5'h10);
    wr(TSEL_ADDR_STATUS, 16'hffff);
    st(16'h0055);
  endtask : t_regs
  task automatic t_illegal();
    i_tsel_xpm.levels(6'h15, 5'h00);
    go(1'b1);
    hi(1);
    chk_bit("error", 1'b1, error_o);
    chk_bit("ready", 1'b1, controller_ready_o);
    st(16'h8015);
    i_tsel_xpm.levels(6'h15, 5'h10);
    go(1'b0);
    hi(0);
    st(16'h0055);
    wr(TSEL_ADDR_CMD_HI, 16'h0000);
    st(16'h8055);
    i_tsel_xpm.levels(6'h15, 5'h18);
    write_function_active_i <= 1'b1;
    go(1'b1);
    hi(1);
    st(16'h8055);
  endtask : t_illegal
  task automatic t_file_mark();
    i_tsel_xpm.levels(6'h15, 5'h10);
    write_function_active_i <= 1'b0;
    go(1'b1);
    hi(0);
    i_tsel_xpm.pulse(0, 0);
    hi(2);
    hi(3);
    st(16'h4055);
  endtask : t_file_mark
  // Late errors wait for the check character
  task automatic t_defer();
    i_tsel_xpm.levels(6'h15, 5'h14);
    read_function_i <= 1'b1;
    go(1'b1);
    hi(0);
    i_tsel_xpm.pulse(1, 2);
    i_tsel_xpm.pulse(3, 0);
    st(16'h3055);
    chk_bit("error", 1'b0, error_o);
    i_tsel_xpm.pulse(2, 0);
    hi(2);
    hi(3);
  endtask : t_defer
  task automatic t_grant_late();
    i_tsel_xpm.levels(6'h15, 5'h12);
    done();
    go(1'b1);
    hi(0);
    i_tsel_xpm.pulse(3, 0);
    hi(4);
    i_tsel_xpm.pulse(4, 1);
    hi(2);
    st(16'h1855);
    done();
    i_tsel_xpm.pulse(3, 0);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk_bit("dma", 1'b0, dma_request_o);
  endtask : t_grant_late
  task automatic t_tape_end();
    i_tsel_xpm.levels(6'h15, 5'h10);
    read_function_i <= 1'b0;
    go(1'b1);
    hi(0);
    i_tsel_xpm.levels(6'h15, 5'h11);
    st(16'h0455);
    chk_bit("error", 1'b0, error_o);
    i_tsel_xpm.pulse(2, 0);
    hi(2);
    i_tsel_xpm.levels(6'h15, 5'h10);
    reverse_motion_i <= 1'b1;
    go(1'b1);
    hi(0);
    i_tsel_xpm.levels(6'h15, 5'h11);
    i_tsel_xpm.pulse(2, 0);
    st(16'h0055);
    chk_bit("error", 1'b0, error_o);
    // Flag set forward, held in reverse, cleared by the marker's trailing edge
    i_tsel_xpm.levels(6'h15, 5'h11);
    reverse_motion_i <= 1'b0;
    st(16'h0455);
    i_tsel_xpm.levels(6'h15, 5'h11);
    reverse_motion_i <= 1'b1;
    st(16'h0455);
    i_tsel_xpm.levels(6'h15, 5'h10);
    st(16'h0055);
  endtask : t_tape_end
  // Unit dropping off-line mid-operation, except for an off-line command
  task automatic t_online();
    i_tsel_xpm.levels(6'h15, 5'h10);
    reverse_motion_i <= 1'b0;
    go(1'b1);
    hi(0);
    i_tsel_xpm.levels(6'h15, 5'h00);
    hi(1);
    st(16'h8015);
    i_tsel_xpm.levels(6'h15, 5'h10);
    offline_function_i <= 1'b1;
    go(1'b1);
    hi(0);
    i_tsel_xpm.levels(6'h15, 5'h00);
    st(16'h0015);
    chk_bit("error", 1'b0, error_o);
  endtask : t_online
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // A hung wait must not stall the run
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_regs();
    t_illegal();
    t_file_mark();
    t_defer();
    t_grant_late();
    t_tape_end();
    t_online();
    end_of_test();
  end
endmodule : tape_status_error_logic_test
